/* File: src/sdcmd_consts.svh */
// Constants for the command decode, clock-gate and byte-mask block.
// Assumes inclusion by the package and the design modules.
`ifndef SDCMD_CONSTS_SVH
`define SDCMD_CONSTS_SVH
`define SDCMD_WAKE_RECOVERY_CYC  2
`define SDCMD_ROW_CYCLE_CYC      10
`define SDCMD_BURST_LEN          4
`define SDCMD_DATA_W             16
`endif

/* File: src/sdcmd_pkg.sv */
// Types for the command decode, clock-gate and byte-mask block.
// Assumes the constants header is available on the include path.
`include "sdcmd_consts.svh"
package sdcmd_pkg;
   typedef struct packed {
      logic       select_n;
      logic       row_strobe_n;
      logic       col_strobe_n;
      logic       write_strobe_n;
      logic       bank_line;
      logic       autoclose_line;
      logic [9:0] addr_low;
   } sdcmd_pins_type;

   typedef enum logic [3:0] {
      SDCMD_NONE, SDCMD_UNSELECTED, SDCMD_NOP, SDCMD_BURST_HALT, SDCMD_READ, SDCMD_STORE,
      SDCMD_ROW_OPEN, SDCMD_BANK_CLOSE, SDCMD_REFRESH, SDCMD_CONFIG_LOAD
   } sdcmd_cmd_type;

   typedef enum logic [2:0] {
      SDCMD_RUN, SDCMD_LOW_POWER, SDCMD_SUSPEND, SDCMD_SELF_REF
   } sdcmd_mode_type;
endpackage : sdcmd_pkg

/* File: src/sdcmd_decode.sv */
// Combinational command decoder from sampled command pins.
// Assumes pins are already synchronised to clk.
`timescale 1ns/1ps
module sdcmd_decode
   import sdcmd_pkg::*;
(
   // Sampled inputs
   input  wire sdcmd_pins_type pins,
   input  wire logic           gate_prev,
   // Decoded command
   output      sdcmd_cmd_type  cmd
);
   always_comb begin
      cmd = SDCMD_NONE;
      if (!gate_prev) begin
         cmd = SDCMD_NONE;
      end else if (pins.select_n) begin
         cmd = SDCMD_UNSELECTED;
      end else begin
         case ({pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n})
            3'h0:    cmd = SDCMD_CONFIG_LOAD;
            3'h1:    cmd = SDCMD_REFRESH;
            3'h2:    cmd = SDCMD_BANK_CLOSE;
            3'h3:    cmd = SDCMD_ROW_OPEN;
            3'h4:    cmd = SDCMD_STORE;
            3'h5:    cmd = SDCMD_READ;
            3'h6:    cmd = SDCMD_BURST_HALT;
            default: cmd = SDCMD_NOP;
         endcase
      end
   end
endmodule : sdcmd_decode

/* File: src/sdcmd_core.sv */
// Command decode, clock-gate control and byte masking of a two-bank SDRAM.
// Assumes all pin inputs are asynchronous to clk and pass two flops first.
`timescale 1ns/1ps
`include "sdcmd_consts.svh"
module sdcmd_core
   import sdcmd_pkg::*;
#(
   parameter int BURST_LEN = `SDCMD_BURST_LEN
)(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Command pins
   input  wire logic           clock_gate_in,
   input  wire sdcmd_pins_type pins_in,
   // Byte gates
   input  wire logic           high_byte_gate,
   input  wire logic           low_byte_gate,
   // Data pins
   input  wire logic [15:0]    dq_in,
   output      logic [15:0]    dq_out,
   output      logic [15:0]    dq_oe,
   // Status
   output      sdcmd_mode_type mode,
   output      logic [1:0]     bank_active,
   output      logic           write_strobe,
   output      logic [15:0]    write_data,
   output      logic [15:0]    write_byte_en,
   output      logic           internal_clk_en,
   output      logic           refresh_pulse,
   output      logic           config_load
);
   sdcmd_pins_type pins_s1_q, pins_q;
   logic           gate_s_q;
   logic           gate_q, gate_prev_q;
   logic [1:0]     bgate_s1_q, bgate_q;
   logic [15:0]    dq_s1_q, dq_q;
   sdcmd_cmd_type  cmd;
   sdcmd_mode_type mode_q;
   logic [1:0]     bank_q;
   logic           rd_q, wr_q, ac_q, bsel_q;
   logic [3:0]     burst_q;
   logic [15:0]    rd_data_q;
   logic           run;

   // Two-stage input synchronisers
   always_ff @(posedge clk) begin
      pins_s1_q  <= pins_in;
      pins_q     <= pins_s1_q;
      gate_s_q   <= clock_gate_in;
      bgate_s1_q <= {high_byte_gate, low_byte_gate};
      bgate_q    <= bgate_s1_q;
      dq_s1_q    <= dq_in;
      dq_q       <= dq_s1_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gate_q      <= 1'b1;
         gate_prev_q <= 1'b1;
      end else begin
         // Second flop of the gate; aligned with pins_q so gate now and pins match
         gate_q      <= gate_s_q;
         gate_prev_q <= gate_q;
      end
   end

   sdcmd_decode u_decode (
      .pins      (pins_q),
      .gate_prev (gate_prev_q),
      .cmd       (cmd)
   );

   // Commands act only in run mode with gate high now, except a refresh on a gate fall with both banks idle, which enters self refresh
   assign run = (mode_q == SDCMD_RUN) && gate_q;

   // Mode control
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_q <= SDCMD_RUN;
      end else begin
         case (mode_q)
            SDCMD_RUN: begin
               if (gate_prev_q && !gate_q) begin
                  if (cmd == SDCMD_REFRESH && bank_q == 2'h0) begin
                     mode_q <= SDCMD_SELF_REF;
                  end else if (rd_q || wr_q) begin
                     mode_q <= SDCMD_SUSPEND;
                  end else if (cmd == SDCMD_UNSELECTED || cmd == SDCMD_NOP) begin
                     mode_q <= SDCMD_LOW_POWER;
                  end else begin
                     mode_q <= SDCMD_SUSPEND;
                  end
               end
            end
            default: begin
               if (gate_q) begin
                  mode_q <= SDCMD_RUN;
               end
            end
         endcase
      end
   end

   // Bank and burst state, frozen outside run
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bank_q  <= 2'h0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         ac_q    <= 1'b0;
         bsel_q  <= 1'b0;
         burst_q <= 4'h0;
      end else if (run) begin
         if (burst_q != 4'h0) begin
            burst_q <= burst_q - 4'h1;
            if (burst_q == 4'h1) begin
               rd_q <= 1'b0;
               wr_q <= 1'b0;
               if (ac_q) begin
                  bank_q[bsel_q] <= 1'b0;
               end
            end
         end
         case (cmd)
            SDCMD_ROW_OPEN: bank_q[pins_q.bank_line] <= 1'b1;
            SDCMD_BANK_CLOSE: begin
               rd_q    <= 1'b0;
               wr_q    <= 1'b0;
               burst_q <= 4'h0;
               if (pins_q.autoclose_line) begin
                  bank_q <= 2'h0;
               end else begin
                  bank_q[pins_q.bank_line] <= 1'b0;
               end
            end
            SDCMD_READ, SDCMD_STORE: begin
               if (bank_q[pins_q.bank_line]) begin
                  rd_q    <= (cmd == SDCMD_READ);
                  wr_q    <= (cmd == SDCMD_STORE);
                  ac_q    <= pins_q.autoclose_line;
                  bsel_q  <= pins_q.bank_line;
                  burst_q <= 4'(BURST_LEN);
               end
            end
            SDCMD_BURST_HALT: begin
               rd_q    <= 1'b0;
               wr_q    <= 1'b0;
               burst_q <= 4'h0;
            end
            default: ;
         endcase
      end
   end

   // Outputs registered; byte gates control each lane independently
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dq_oe         <= 16'h0000;
         dq_out        <= 16'h0000;
         write_strobe  <= 1'b0;
         write_data    <= 16'h0000;
         write_byte_en <= 16'h0000;
         rd_data_q     <= 16'h0000;
         refresh_pulse <= 1'b0;
         config_load   <= 1'b0;
         internal_clk_en <= 1'b1;
      end else begin
         internal_clk_en <= (mode_q == SDCMD_RUN);
         refresh_pulse <= run && cmd == SDCMD_REFRESH && bank_q == 2'h0;
         config_load   <= run && cmd == SDCMD_CONFIG_LOAD;
         rd_data_q     <= rd_data_q + 16'h0001;
         dq_out        <= rd_data_q;
         dq_oe[15:8]   <= {8{run && rd_q && gate_prev_q && !bgate_q[1]}};
         dq_oe[7:0]    <= {8{run && rd_q && gate_prev_q && !bgate_q[0]}};
         write_strobe  <= run && (wr_q || cmd == SDCMD_STORE);
         write_data    <= dq_q;
         write_byte_en <= {{8{!bgate_q[1]}}, {8{!bgate_q[0]}}};
      end
   end

   assign mode            = mode_q;
   assign bank_active     = bank_q;

   // Gate seen high last cycle and low now
   sequence s_gate_fall;
      gate_prev_q && !gate_q;
   endsequence

   property p_unsel;
      @(posedge clk) disable iff (!rst_b)
      (cmd == SDCMD_UNSELECTED) |=> !config_load && !refresh_pulse;
   endproperty
   a_unsel: assert property (p_unsel)
      else $error("unselected cycle acted");

   property p_suspend;
      @(posedge clk) disable iff (!rst_b)
      (mode_q == SDCMD_SUSPEND) |=> $stable(bank_q) && $stable(burst_q);
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("state changed in suspend");

   property p_mask;
      @(posedge clk) disable iff (!rst_b)
      (bgate_q == 2'h3) |=> dq_oe == 16'h0000 && write_byte_en == 16'h0000;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked byte lanes active");

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
      (mode_q != SDCMD_RUN && gate_q) |=> mode_q == SDCMD_RUN;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wake on gate high");

   property p_low_power;
      @(posedge clk) disable iff (!rst_b)
      (mode_q == SDCMD_LOW_POWER) |=> $stable(bank_q) && !config_load && !refresh_pulse;
   endproperty
   a_low_power: assert property (p_low_power)
      else $error("command acted in low power");

   property p_self_ref;
      @(posedge clk) disable iff (!rst_b)
      (mode_q == SDCMD_SELF_REF) |=> !refresh_pulse && dq_oe == 16'h0000;
   endproperty
   a_self_ref: assert property (p_self_ref)
      else $error("self refresh drove data or pulsed");

   property p_fall;
      @(posedge clk) disable iff (!rst_b)
      (mode_q == SDCMD_RUN) ##0 s_gate_fall |=> mode_q != SDCMD_RUN;
   endproperty
   a_fall: assert property (p_fall)
      else $error("gate fall left mode in run");
endmodule : sdcmd_core

/* File: tb/sdcmd_ctrl_model.sv */
// Controller model driving the command pins and clock gate of the core.
// Assumes the bench calls its tasks from one process, in step with clk.
`timescale 1ns/1ps
`include "sdcmd_consts.svh"
module sdcmd_ctrl_model
   import sdcmd_pkg::*;
(
   // Clock
   input  wire logic     clk,
   // Command pins
   output logic           clock_gate_in,
   output sdcmd_pins_type pins_in
);
   initial begin
      clock_gate_in = 1'b1;
      pins_in       = 16'hF000;
   end
   // Code is select, row, column, write, bank, autoclose
   task automatic send(input logic [5:0] c, input logic gate);
      @(posedge clk);
      pins_in       <= {c, 10'($urandom)};
      clock_gate_in <= gate;
      @(posedge clk);
      pins_in       <= {4'h7, 2'h0, 10'($urandom)};
   endtask : send
   // Short low periods keep refresh in time
   task automatic gate_down();
      @(posedge clk);
      clock_gate_in <= 1'b0;
   endtask : gate_down
   task automatic gate_up(input logic self_exit);
      @(posedge clk);
      clock_gate_in <= 1'b1;
      repeat ((self_exit ? `SDCMD_ROW_CYCLE_CYC : `SDCMD_WAKE_RECOVERY_CYC) + 3) @(posedge clk);
   endtask : gate_up
endmodule : sdcmd_ctrl_model

/* File: tb/sdram_cmd_cke_mask_decode_tb.sv */
// Self-checking bench of the command, clock-gate and byte-mask core.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
module sdram_cmd_cke_mask_decode_tb;
   import sdcmd_pkg::*;
   logic clk, rst_b, clock_gate_in, high_byte_gate, low_byte_gate, write_strobe;
   logic internal_clk_en, refresh_pulse, config_load, rp_seen, cl_seen;
   logic [15:0] dq_in, dq_out, dq_oe, write_data, write_byte_en, oe_acc, wbe_seen;
   logic [15:0] dq_h1, dq_h2, dq_h3, dq_p;
   logic [1:0] bank_active;
   sdcmd_pins_type pins_in;
   sdcmd_mode_type mode;
   int n_mismatch = 0, n_tests = 0, cyc = 0, i;
   sdcmd_core sdcmd_core_i (.clk(clk), .rst_b(rst_b), .clock_gate_in(clock_gate_in), .pins_in(pins_in),
      .high_byte_gate(high_byte_gate), .low_byte_gate(low_byte_gate), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .mode(mode), .bank_active(bank_active), .write_strobe(write_strobe),
      .write_data(write_data), .write_byte_en(write_byte_en), .internal_clk_en(internal_clk_en),
      .refresh_pulse(refresh_pulse), .config_load(config_load));
   sdcmd_ctrl_model m (.clk(clk), .clock_gate_in(clock_gate_in), .pins_in(pins_in));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [15:0] lanes(input logic h, input logic l);
      return {{8{~h}}, {8{~l}}};
   endfunction : lanes
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic clr();
      @(negedge clk);
      rp_seen  = 1'b0;
      cl_seen  = 1'b0;
      oe_acc   = 16'h0000;
      wbe_seen = 16'hXXXX;
   endtask : clr
   task automatic go(input logic [5:0] c, input logic gate, input int n);
      clr();
      m.send(c, gate);
      repeat (n) @(posedge clk);
   endtask : go
   always @(posedge clk) begin
      if (refresh_pulse) rp_seen <= 1'b1;
      if (config_load) cl_seen <= 1'b1;
      if (write_strobe) wbe_seen <= write_byte_en;
      oe_acc <= oe_acc | dq_oe;
      // Write data lags the pin by three edges
      if (write_strobe) chk(write_data, dq_h3);
      // Read data is a running count while lanes drive
      if (cyc > 12 && dq_oe != 16'h0000) chk(dq_out, dq_p + 16'h0001);
      dq_h1  <= dq_in;
      dq_h2  <= dq_h1;
      dq_h3  <= dq_h2;
      dq_p   <= dq_out;
      dq_in  <= 16'($urandom);
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(32'hB3D3C756));
      rst_b = 1'b0;
      high_byte_gate = 1'b0;
      low_byte_gate = 1'b0;
      dq_in = 16'h0000;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      chk(16'(bank_active), 16'h0000);
      go(6'h24, 1'b1, 8); chk(16'(rp_seen), 16'h0000);
      go(6'h00, 1'b1, 8); chk(16'(cl_seen), 16'h0001);
      go(6'h04, 1'b1, 8); chk(16'(rp_seen), 16'h0001);
      go(6'h0C, 1'b1, 8);
      go(6'h0E, 1'b1, 8); chk(16'(bank_active), 16'h0003);
      for (i = 0; i < 8; i++) begin
         high_byte_gate <= (i < 4) ? i[1] : 1'($urandom);
         low_byte_gate  <= (i < 4) ? i[0] : 1'($urandom);
         go(6'h10, 1'b1, 8); chk(wbe_seen, lanes(high_byte_gate, low_byte_gate));
         go(6'h14, 1'b1, 10); chk(oe_acc, lanes(high_byte_gate, low_byte_gate));
      end
      chk(16'(bank_active), 16'h0003);
      go(6'h17, 1'b1, 12); chk(16'(bank_active), 16'h0001);
      go(6'h0E, 1'b1, 8);
      go(6'h08, 1'b1, 8); chk(16'(bank_active), 16'h0002);
      go(6'h0C, 1'b1, 8);
      go(6'h09, 1'b1, 8); chk(16'(bank_active), 16'h0000);
      m.gate_down();
      repeat (8) @(posedge clk);
      chk(16'(mode), 16'(SDCMD_LOW_POWER));
      chk(16'(internal_clk_en), 16'h0000);
      go(6'h00, 1'b0, 6); chk(16'(cl_seen), 16'h0000);
      m.gate_up(1'b0); chk(16'(mode), 16'(SDCMD_RUN));
      go(6'h0C, 1'b1, 8);
      go(6'h10, 1'b1, 1);
      m.gate_down();
      repeat (4) @(posedge clk);
      chk(16'(mode), 16'(SDCMD_SUSPEND));
      go(6'h0E, 1'b0, 6); chk(16'(bank_active), 16'h0001);
      m.gate_up(1'b0); chk(16'(mode), 16'(SDCMD_RUN));
      repeat (8) @(posedge clk);
      go(6'h09, 1'b1, 8);
      go(6'h04, 1'b0, 8); chk(16'(mode), 16'(SDCMD_SELF_REF));
      m.gate_up(1'b1); chk(16'(mode), 16'(SDCMD_RUN));
      complete_run();
   end
endmodule : sdram_cmd_cke_mask_decode_tb
